// ==== verilog/dmc_pkg.sv ====
package dmc_pkg;

	// ********************************************************************
	// Register map
	// ********************************************************************
	localparam logic [7:0] DMC_CH0_SRC_LOW_OFS   = 8'hee;
	localparam logic [7:0] DMC_CH0_SRC_HIGH_OFS  = 8'hef;
	localparam logic [7:0] DMC_CH0_SRC_UPPER_OFS = 8'hf0;
	localparam logic [7:0] DMC_CH0_DST_LOW_OFS   = 8'hf1;
	localparam logic [7:0] DMC_CH0_DST_HIGH_OFS  = 8'hf2;
	localparam logic [7:0] DMC_CH0_DST_UPPER_OFS = 8'hf3;
	localparam logic [7:0] DMC_CH0_COUNT_LOW_OFS = 8'hf4;
	localparam logic [7:0] DMC_CH0_COUNT_HIGH_OFS = 8'hf5;
	localparam logic [7:0] DMC_CH0_CONTROL_OFS   = 8'hf6;
	localparam logic [7:0] DMC_CH1_SRC_LOW_OFS   = 8'hf7;
	localparam logic [7:0] DMC_CH1_SRC_HIGH_OFS  = 8'hf8;
	localparam logic [7:0] DMC_CH1_SRC_UPPER_OFS = 8'hf9;
	localparam logic [7:0] DMC_CH1_DST_LOW_OFS   = 8'hfa;
	localparam logic [7:0] DMC_CH1_DST_HIGH_OFS  = 8'hfb;
	localparam logic [7:0] DMC_CH1_DST_UPPER_OFS = 8'hfc;
	localparam logic [7:0] DMC_CH1_COUNT_LOW_OFS = 8'hfd;
	localparam logic [7:0] DMC_CH1_COUNT_HIGH_OFS = 8'hfe;
	localparam logic [7:0] DMC_CH1_CONTROL_OFS   = 8'hff;

	// Register position inside one channel's block of nine
	localparam logic [3:0] DMC_REGS_PER_CH = 4'h9;
	localparam logic [3:0] DMC_SUB_SRC_L   = 4'h0;
	localparam logic [3:0] DMC_SUB_SRC_H   = 4'h1;
	localparam logic [3:0] DMC_SUB_SRC_U   = 4'h2;
	localparam logic [3:0] DMC_SUB_DST_L   = 4'h3;
	localparam logic [3:0] DMC_SUB_DST_H   = 4'h4;
	localparam logic [3:0] DMC_SUB_DST_U   = 4'h5;
	localparam logic [3:0] DMC_SUB_CNT_L   = 4'h6;
	localparam logic [3:0] DMC_SUB_CNT_H   = 4'h7;
	localparam logic [3:0] DMC_SUB_CTL     = 4'h8;

	// ********************************************************************
	// Control register fields and reset values
	// ********************************************************************
	localparam int DMC_CTL_EN_BIT    = 7;
	localparam int DMC_CTL_IE_BIT    = 6;
	localparam int DMC_CTL_BURST_BIT = 4;
	localparam int DMC_CTL_DST_LSB   = 2;
	localparam int DMC_CTL_SRC_LSB   = 0;
	localparam logic [7:0]  DMC_CTL_RESET   = 8'h00;
	localparam logic [15:0] DMC_COUNT_RESET = 16'h0000;
	localparam logic [7:0]  DMC_CTL_WMASK   = 8'hdf;

	// Address step codes
	localparam logic [1:0] DMC_STEP_INC = 2'h0;
	localparam logic [1:0] DMC_STEP_DEC = 2'h1;

	// ********************************************************************
	// Timing
	// ********************************************************************
	localparam logic [3:0] DMC_STEAL_GAP_CYCLES = 4'h8;

	typedef enum logic [2:0] {
		DMC_ST_IDLE = 3'b000,
		DMC_ST_REQ  = 3'b001,
		DMC_ST_RD   = 3'b010,
		DMC_ST_WR   = 3'b011,
		DMC_ST_GAP  = 3'b100
	} dmc_state_e;

	typedef enum logic [1:0] {
		DMC_OWN_CPU = 2'b00,
		DMC_OWN_DMA = 2'b01,
		DMC_OWN_EXT = 2'b10
	} dmc_owner_e;

endpackage : dmc_pkg

// ==== verilog/dmc_dual_channel_memory_dma.sv ====
`timescale 1ns/1ps

// Summary of operation
// - Two channels, each with 24-bit source, destination, 16-bit count, control.
// - Whole-block mode keeps the bus until the full block is moved.
// - Cycle-steal moves one byte, releases bus, waits 8 cycles, repeats.
// - Channels only drive memory strobes, never the internal I/O registers.
// - Enabled channel drives address, data, read and write strobes.
// - Disabled channel raises no request and moves no data.
// - Both channels are disabled after reset.
// - External master requests by low input; internal request wins ties.
// - Control bit 4 set selects whole-block, clear selects cycle-steal.
// - Cycle-steal is the mode after reset.
// - Channel 0 outranks channel 1; block-mode channel 0 finishes first.
// - Both cycle-steal: channels alternate bytes with 8-cycle gaps.
// - Channel 0 cycle-steal with channel 1 block holds channel 1 off.
// - Control bit 6 set raises interrupt when byte count reaches zero.
// - Channel interrupts are disabled after reset.
// - Pending interrupt clears only by clearing enable, not interrupt enable.
// - All channel registers are reached through the I/O port.
// - Address registers undefined after reset; count and control read zero.
// - Count decrements per byte, transfer ends at zero, 1 to 65535.
// - Source and destination step up, down or stay after each byte.
// - Enable bit is not cleared by hardware when transfer completes.
module dmc_dual_channel_memory_dma
	import dmc_pkg::*;
#(
	parameter int ADDR_W = 24,
	parameter int CNT_W  = 16
)(
	input  wire logic              clk,
	input  wire logic              rstn,
	input  wire logic              clk_en,
	input  wire logic [7:0]        io_addr,
	input  wire logic [7:0]        io_wdata,
	input  wire logic              io_wr,
	input  wire logic              io_rd,
	output logic      [7:0]        io_rdata,
	output logic                   bus_request,
	input  wire logic              bus_ack,
	input  wire logic              external_bus_request_n,
	output logic                   external_bus_grant_n,
	output logic      [ADDR_W-1:0] mem_addr,
	output logic      [7:0]        mem_wdata,
	input  wire logic [7:0]        mem_rdata,
	output logic                   mem_rd_n,
	output logic                   mem_wr_n,
	output logic                   bus_oe_n,
	output logic      [1:0]        irq
);

	// ********************************************************************
	// Helpers
	// ********************************************************************
	// Step codes: 00 counts up, 01 counts down, 1x holds the address
	function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a,
		input logic [1:0] mode);
		logic [ADDR_W-1:0] r;
		r = a;
		if (mode == DMC_STEP_INC)
			r = a + {{(ADDR_W-1){1'b0}}, 1'b1};
		else if (mode == DMC_STEP_DEC)
			r = a - {{(ADDR_W-1){1'b0}}, 1'b1};
		return r;
	endfunction : step_addr

	function automatic logic [7:0] byte_of(input logic [ADDR_W-1:0] a,
		input logic [1:0] sel);
		logic [ADDR_W-1:0] s;
		s = a >> {sel, 3'b000};
		return s[7:0];
	endfunction : byte_of

	// ********************************************************************
	// Channel registers
	// ********************************************************************
	logic [ADDR_W-1:0] src_q   [2];
	logic [ADDR_W-1:0] dst_q   [2];
	logic [CNT_W-1:0]  cnt_q   [2];
	logic [7:0]        ctl_q   [2];
	logic [1:0]        irq_q;
	logic [7:0]        rdata_q;

	dmc_state_e        state_q;
	dmc_owner_e        owner_q;
	logic              cur_q;
	logic              last_q;
	logic [3:0]        gap_q;
	logic [ADDR_W-1:0] addr_q;
	logic [7:0]        data_q;
	logic              rd_n_q;
	logic              wr_n_q;
	logic              drive_q;

	// ********************************************************************
	// I/O decode
	// ********************************************************************
	wire       io_hit    = io_addr >= DMC_CH0_SRC_LOW_OFS;
	wire [7:0] io_rel    = io_addr - DMC_CH0_SRC_LOW_OFS;
	// Channel 1 sits nine registers above channel 0
	wire       io_ch     = io_rel[3:0] >= DMC_REGS_PER_CH || io_rel[4];
	wire [7:0] io_sub8   = io_ch ? io_rel - {4'h0, DMC_REGS_PER_CH} : io_rel;
	wire [3:0] io_sub    = io_sub8[3:0];
	wire       io_wr_hit = io_wr && io_hit;

	// ********************************************************************
	// Channel status and selection
	// ********************************************************************
	wire [1:0] en;
	wire [1:0] burst;
	wire [1:0] ready;
	// A zero count asks for nothing, so an enable left set after completion is harmless
	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_stat
			assign en[g]    = ctl_q[g][DMC_CTL_EN_BIT];
			assign burst[g] = ctl_q[g][DMC_CTL_BURST_BIT];
			assign ready[g] = en[g] && (cnt_q[g] != '0);
		end
	endgenerate

	// Channel 1 only runs when channel 0 is idle, or both steal and it is its turn
	wire pick1 = ready[1] && (!ready[0] ||
		(!burst[0] && !burst[1] && !last_q));
	wire any_ready = |ready;
	wire cur_en    = en[cur_q];
	wire granted   = bus_ack && (owner_q == DMC_OWN_DMA);

	// Count and addresses advance together, once the write strobe has gone out
	wire [CNT_W-1:0]  cnt_dec  = cnt_q[cur_q] - {{(CNT_W-1){1'b0}}, 1'b1};
	wire [ADDR_W-1:0] src_next = step_addr(src_q[cur_q],
		ctl_q[cur_q][DMC_CTL_SRC_LSB+1:DMC_CTL_SRC_LSB]);
	wire [ADDR_W-1:0] dst_next = step_addr(dst_q[cur_q],
		ctl_q[cur_q][DMC_CTL_DST_LSB+1:DMC_CTL_DST_LSB]);
	wire byte_done  = (state_q == DMC_ST_WR);
	// Burst chains the next read straight after the write, with no request cycle between
	wire more_burst = burst[cur_q] && cur_en && (cnt_dec != '0);

	// The request stands through REQ, RD and WR only; GAP and IDLE leave the bus to the CPU
	wire int_req = (state_q == DMC_ST_REQ) || (state_q == DMC_ST_RD) ||
		(state_q == DMC_ST_WR);
	wire ext_req = !external_bus_request_n;

	// ********************************************************************
	// Register file
	// ********************************************************************
	// Address registers carry no reset; their value after reset is undefined
	generate
		for (g = 0; g < 2; g++)
		begin : g_addr
			// Per-channel write decode; a CPU write beats the hardware update
			wire       sel      = io_wr_hit && (io_ch == 1'(g));
			wire       own      = byte_done && (cur_q == 1'(g));
			wire       wr_src   = sel && (io_sub <= DMC_SUB_SRC_U);
			wire       wr_dst   = sel && (io_sub >= DMC_SUB_DST_L) && (io_sub <= DMC_SUB_DST_U);
			wire       wr_cnt_l = sel && (io_sub == DMC_SUB_CNT_L);
			wire       wr_cnt_h = sel && (io_sub == DMC_SUB_CNT_H);
			wire       wr_ctl   = sel && (io_sub == DMC_SUB_CTL);
			wire       irq_set  = own && (cnt_dec == '0) && ctl_q[g][DMC_CTL_IE_BIT];
			wire [1:0] dst_byte = io_sub[1:0] - 2'h3;
			always_ff @(posedge clk)
			begin
				if (clk_en)
				begin
					if (wr_src)
						src_q[g][{io_sub[1:0], 3'b000} +: 8] <= io_wdata;
					else if (own)
						src_q[g] <= src_next;
					if (wr_dst)
						dst_q[g][{dst_byte, 3'b000} +: 8] <= io_wdata;
					else if (own)
						dst_q[g] <= dst_next;
				end
			end

			always_ff @(posedge clk or negedge rstn)
			begin
				if (!rstn)
				begin
					cnt_q[g] <= DMC_COUNT_RESET;
					ctl_q[g] <= DMC_CTL_RESET;
					irq_q[g] <= 1'b0;
				end
				else if (clk_en)
				begin
					if (wr_cnt_l)
						cnt_q[g][7:0] <= io_wdata;
					else if (wr_cnt_h)
						cnt_q[g][15:8] <= io_wdata;
					else if (own)
						cnt_q[g] <= cnt_dec;
					// Enable stays set after completion, only software clears it
					if (wr_ctl)
						ctl_q[g] <= io_wdata & DMC_CTL_WMASK;
					// Completion sets the request even if enable is cleared together
					if (irq_set)
						irq_q[g] <= 1'b1;
					else if (!en[g])
						irq_q[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// ********************************************************************
	// Register read
	// ********************************************************************
	// Read data is registered so that it cannot follow io_addr glitches
	logic [7:0] rd_mux;
	always_comb
	begin
		rd_mux = 8'h00;
		if (io_sub <= DMC_SUB_SRC_U)
			rd_mux = byte_of(src_q[io_ch], io_sub[1:0]);
		else if (io_sub <= DMC_SUB_DST_U)
			rd_mux = byte_of(dst_q[io_ch], io_sub[1:0] - 2'h3);
		else if (io_sub == DMC_SUB_CNT_L)
			rd_mux = cnt_q[io_ch][7:0];
		else if (io_sub == DMC_SUB_CNT_H)
			rd_mux = cnt_q[io_ch][15:8];
		else if (io_sub == DMC_SUB_CTL)
			rd_mux = ctl_q[io_ch];
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rdata_q <= 8'h00;
		else if (clk_en && io_rd)
			rdata_q <= io_hit ? rd_mux : 8'h00;
	end

	// ********************************************************************
	// Bus ownership
	// ********************************************************************
	// Owner follows the acknowledge one edge later; the internal request is looked at first
	wire take_dma  = bus_ack && int_req;
	wire take_ext  = bus_ack && ext_req && !int_req;
	wire ext_owned = bus_ack && (owner_q == DMC_OWN_EXT);
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			owner_q <= DMC_OWN_CPU;
		else if (clk_en)
		begin
			case (owner_q)
				DMC_OWN_CPU:
					if (take_dma)
						owner_q <= DMC_OWN_DMA;
					else if (take_ext)
						owner_q <= DMC_OWN_EXT;
				DMC_OWN_DMA:
					if (!int_req)
						owner_q <= DMC_OWN_CPU;
				DMC_OWN_EXT:
					if (!ext_req)
						owner_q <= DMC_OWN_CPU;
				default:
					owner_q <= DMC_OWN_CPU;
			endcase
		end
	end

	// ********************************************************************
	// Transfer sequencer
	// ********************************************************************
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_q <= DMC_ST_IDLE;
			cur_q   <= 1'b0;
			last_q  <= 1'b1;
			gap_q   <= 4'h0;
			addr_q  <= '0;
			data_q  <= 8'h00;
			rd_n_q  <= 1'b1;
			wr_n_q  <= 1'b1;
			drive_q <= 1'b0;
		end
		else if (clk_en)
		begin
			case (state_q)
				DMC_ST_IDLE:
					if (any_ready)
					begin
						// The channel chosen here is kept for the whole byte
						cur_q   <= pick1;
						state_q <= DMC_ST_REQ;
					end
				DMC_ST_REQ:
					if (!cur_en)
						state_q <= DMC_ST_IDLE;
					else if (granted)
					begin
						addr_q  <= src_q[cur_q];
						rd_n_q  <= 1'b0;
						drive_q <= 1'b1;
						state_q <= DMC_ST_RD;
					end
				DMC_ST_RD:
				begin
					rd_n_q <= 1'b1;
					// Disabled between read and write: the byte is dropped, nothing is written
					if (!cur_en)
					begin
						drive_q <= 1'b0;
						state_q <= DMC_ST_IDLE;
					end
					else
					begin
						data_q  <= mem_rdata;
						addr_q  <= dst_q[cur_q];
						wr_n_q  <= 1'b0;
						state_q <= DMC_ST_WR;
					end
				end
				DMC_ST_WR:
				begin
					wr_n_q <= 1'b1;
					// Remembered for the steal-mode alternation
					last_q <= cur_q;
					if (more_burst)
					begin
						addr_q  <= src_next;
						rd_n_q  <= 1'b0;
						state_q <= DMC_ST_RD;
					end
					else if (burst[cur_q])
					begin
						drive_q <= 1'b0;
						state_q <= DMC_ST_IDLE;
					end
					else
					begin
						// Bus goes back to the CPU for a fixed quiet spell
						drive_q <= 1'b0;
						gap_q   <= DMC_STEAL_GAP_CYCLES - 4'h1;
						state_q <= DMC_ST_GAP;
					end
				end
				// Quiet spell counts down to zero, then one IDLE cycle before the next request
				DMC_ST_GAP:
					if (gap_q == 4'h0)
						state_q <= DMC_ST_IDLE;
					else
						gap_q <= gap_q - 4'h1;
				default:
					state_q <= DMC_ST_IDLE;
			endcase
		end
	end

	// ********************************************************************
	// Outputs
	// ********************************************************************
	// Only memory strobes exist here, so internal I/O space is never touched
	assign mem_addr             = addr_q;
	assign mem_wdata            = data_q;
	assign mem_rd_n             = rd_n_q;
	assign mem_wr_n             = wr_n_q;
	assign bus_oe_n             = !drive_q;
	assign bus_request          = int_req || ext_req;
	assign external_bus_grant_n = !ext_owned;
	assign io_rdata             = rdata_q;
	assign irq                  = irq_q;

endmodule : dmc_dual_channel_memory_dma

// ==== tb/dmc_dma_asserts.sv ====
`timescale 1ns/1ps
// ********************************************************************
// Port checks
// ********************************************************************
module dmc_dma_asserts (
	input wire logic       clk,
	input wire logic       rstn,
	input wire logic       clk_en,
	input wire logic [7:0] io_addr,
	input wire logic       io_wr,
	input wire logic       io_rd,
	input wire logic [7:0] io_rdata,
	input wire logic       bus_request,
	input wire logic       bus_ack,
	input wire logic       external_bus_request_n,
	input wire logic       external_bus_grant_n,
	input wire logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata,
	input wire logic       mem_rd_n,
	input wire logic       mem_wr_n,
	input wire logic       bus_oe_n,
	input wire logic [1:0] irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_rd; !mem_rd_n; endsequence
	sequence s_wr; !mem_wr_n; endsequence
	property p_rd_pulse; s_rd |=> mem_rd_n; endproperty
	property p_rd_wr; s_rd |=> !mem_wr_n || bus_oe_n; endproperty
	property p_copy; s_rd ##1 s_wr |-> mem_wdata == $past(mem_rdata); endproperty
	property p_owned; !bus_oe_n |-> bus_ack; endproperty
	property p_ext_yield; !external_bus_grant_n |-> bus_oe_n; endproperty
	property p_ext_req; !external_bus_request_n |-> bus_request; endproperty
	property p_grant; !external_bus_grant_n |-> !$past(external_bus_request_n); endproperty
	property p_irq_set;
		$rose(irq[0]) || $rose(irq[1]) |-> !$past(mem_wr_n) || !$past(mem_wr_n, 2);
	endproperty
	property p_irq_clr;
		$fell(irq[0]) || $fell(irq[1]) |-> $past(io_wr) || $past(io_wr, 2);
	endproperty
	property p_unmapped; io_rd && clk_en && io_addr < 8'hee |=> io_rdata == 8'h00; endproperty
	a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long");
	a_rd_wr: assert property (p_rd_wr) else $error("read not followed by write");
	a_copy: assert property (p_copy) else $error("written byte differs from read");
	a_owned: assert property (p_owned) else $error("bus driven without release");
	a_ext_yield: assert property (p_ext_yield) else $error("bus driven during grant");
	a_ext_req: assert property (p_ext_req) else $error("external request not passed");
	a_grant: assert property (p_grant) else $error("grant without request");
	a_irq_set: assert property (p_irq_set) else $error("irq rose without a byte");
	a_irq_clr: assert property (p_irq_clr) else $error("irq fell without write");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : dmc_dma_asserts

bind dmc_dual_channel_memory_dma dmc_dma_asserts u_chk (.clk, .rstn, .clk_en, .io_addr,
	.io_wr, .io_rd, .io_rdata, .bus_request, .bus_ack, .external_bus_request_n,
	.external_bus_grant_n, .mem_wdata, .mem_rdata, .mem_rd_n, .mem_wr_n, .bus_oe_n, .irq);

// ==== tb/dmc_bus_model.sv ====
`timescale 1ns/1ps
// ********************************************************************
// CPU arbiter and memory
// ********************************************************************
module dmc_bus_model (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        slow,
	input  wire logic        bus_request,
	input  wire logic [23:0] mem_addr,
	input  wire logic        mem_rd_n,
	output logic             bus_ack,
	output logic      [7:0]  mem_rdata
);
	logic [1:0] wait_q;
	logic [7:0] last_q;
	// Released data lines show a changing value, never the last byte
	assign mem_rdata = mem_rd_n ? ~last_q : mem_addr[7:0] ^ mem_addr[15:8] ^ mem_addr[23:16] ^ 8'h3c;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			bus_ack <= 1'b0;
			wait_q <= 2'h0;
			last_q <= 8'h00;
		end
		else
		begin
			last_q <= mem_rdata;
			if (!bus_request)
			begin
				bus_ack <= 1'b0;
				wait_q <= slow ? 2'h3 : 2'h0;
			end
			else if (wait_q != 2'h0)
				wait_q <= wait_q - 2'h1;
			else
				bus_ack <= 1'b1;
		end
	end
endmodule : dmc_bus_model

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
	import dmc_pkg::*;
	logic clk = 0, rstn = 0, clk_en = 1, io_wr = 0, io_rd = 0, slow = 0;
	logic external_bus_request_n = 1, external_bus_grant_n, bus_request, bus_ack;
	logic mem_rd_n, mem_wr_n, bus_oe_n;
	logic [7:0] io_addr = 0, io_wdata = 0, io_rdata, mem_wdata, mem_rdata, ctl_a[2];
	logic [1:0] irq;
	logic [23:0] mem_addr;
	logic [33:0] exp_q[$], ch_q[2][$], mon_e;
	int n_errors = 0, checks = 0, cyc = 0, last_wr = 0;
	always #25 clk = ~clk;
	dmc_dual_channel_memory_dma dut_u (.clk, .rstn, .clk_en, .io_addr, .io_wdata, .io_wr,
		.io_rd, .io_rdata, .bus_request, .bus_ack, .external_bus_request_n,
		.external_bus_grant_n, .mem_addr, .mem_wdata, .mem_rdata, .mem_rd_n, .mem_wr_n,
		.bus_oe_n, .irq);
	dmc_bus_model cpu_u (.clk, .rstn, .slow, .bus_request, .mem_addr, .mem_rd_n, .bus_ack,
		.mem_rdata);
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic end_sim;
		if (n_errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	function automatic logic [23:0] step(input logic [23:0] a, input logic [1:0] c);
		return c[1] ? a : (c[0] ? a - 24'h1 : a + 24'h1);
	endfunction : step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		@(negedge clk);
		io_wr = 1'b0;
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		io_addr = a;
		io_rd = 1'b1;
		@(negedge clk);
		io_rd = 1'b0;
		check("io_rdata", 32'(io_rdata), 32'(e));
	endtask : rdc
	// Expected bytes are queued per channel; the enable is left for go
	task automatic prog(input int ch, input logic [23:0] s, input logic [23:0] d,
		input logic [15:0] n, input logic [7:0] ctl);
		logic [7:0] b;
		b = ch ? DMC_CH1_SRC_LOW_OFS : DMC_CH0_SRC_LOW_OFS;
		ctl_a[ch] = ctl;
		wr(b + 8'h8, ctl & 8'h7f);
		for (int i = 0; i < 3; i++)
		begin
			wr(b + 8'(i), s[8*i+:8]);
			wr(b + 8'(i + 3), d[8*i+:8]);
		end
		wr(b + 8'h6, n[7:0]);
		wr(b + 8'h7, n[15:8]);
		for (int i = 0; i < n && ctl[7]; i++)
		begin
			ch_q[ch].push_back({i == 0 ? 2'h0 : (ctl[4] ? 2'h1 : 2'h2), d,
				s[7:0] ^ s[15:8] ^ s[23:16] ^ 8'h3c});
			s = step(s, ctl[1:0]);
			d = step(d, ctl[3:2]);
		end
	endtask : prog
	task automatic go(input bit alt);
		while (ch_q[0].size() + ch_q[1].size() > 0)
		begin
			if (ch_q[0].size() > 0)
				exp_q.push_back(ch_q[0].pop_front());
			if (ch_q[1].size() > 0 && (alt || ch_q[0].size() == 0))
				exp_q.push_back(ch_q[1].pop_front());
		end
		wr(DMC_CH0_CONTROL_OFS, ctl_a[0]);
		wr(DMC_CH1_CONTROL_OFS, ctl_a[1]);
		repeat (20) @(negedge clk);
		for (int i = 0; i < 4000 && (exp_q.size() > 0 || bus_request !== 1'b0); i++)
			@(negedge clk);
		check("pending", 32'(exp_q.size()), 0);
	endtask : go
	// ********************************************************************
	// Memory write monitor
	// ********************************************************************
	always @(posedge clk)
	begin
		if (rstn && mem_wr_n === 1'b0)
		begin
			mon_e = exp_q.size() ? exp_q.pop_front() : 34'h3ffffffff;
			check("write", {mem_addr, mem_wdata}, mon_e[31:0]);
			if (mon_e[33:32] == 2'h1)
				check("burst gap", 32'(cyc - last_wr), 2);
			if (mon_e[33:32] == 2'h2)
				check("steal gap", 32'(cyc - last_wr >= 10), 1);
			last_wr = cyc;
		end
		cyc++;
	end
	initial
	begin
		#1000000;
		n_errors++;
		end_sim();
	end
	initial
	begin
		void'($urandom(32'hb08fd796));
		ctl_a[0] = 8'h00;
		ctl_a[1] = 8'h00;
		repeat (10) @(negedge clk);
		rstn = 1'b1;
		for (int a = 'hee; a <= 'hff; a++)
			if ((a - 'hee) % 9 >= 6)
				rdc(8'(a), 8'h00);
		rdc(8'h80, 8'h00);
		wr(DMC_CH0_SRC_HIGH_OFS, 8'ha5);
		rdc(DMC_CH0_SRC_HIGH_OFS, 8'ha5);
		wr(DMC_CH1_DST_UPPER_OFS, 8'h5a);
		rdc(DMC_CH1_DST_UPPER_OFS, 8'h5a);
		prog(0, 24'($urandom), 24'($urandom), 3, 8'hc4);
		go(0);
		rdc(DMC_CH0_COUNT_LOW_OFS, 8'h00);
		rdc(DMC_CH0_CONTROL_OFS, 8'hc4);
		check("irq", 32'(irq), 1);
		wr(DMC_CH0_CONTROL_OFS, 8'h84);
		check("irq", 32'(irq), 1);
		wr(DMC_CH0_CONTROL_OFS, 8'h00);
		@(negedge clk);
		check("irq", 32'(irq), 0);
		prog(0, 24'($urandom), 24'($urandom), 4, 8'h93);
		prog(1, 24'($urandom), 24'($urandom), 1, 8'h8c);
		go(0);
		slow = 1'b1;
		prog(0, 24'($urandom), 24'($urandom), 16'(2 + $urandom % 3), 8'h80 | 8'($urandom % 16));
		prog(1, 24'($urandom), 24'($urandom), 16'(2 + $urandom % 3), 8'h80 | 8'($urandom % 16));
		go(1);
		slow = 1'b0;
		prog(0, 24'($urandom), 24'($urandom), 2, 8'h80);
		prog(1, 24'($urandom), 24'($urandom), 3, 8'h90);
		go(0);
		prog(0, 24'($urandom), 24'($urandom), 5, 8'h10);
		prog(1, 24'($urandom), 24'($urandom), 5, 8'h00);
		go(0);
		external_bus_request_n = 1'b0;
		for (int i = 0; i < 20 && external_bus_grant_n !== 1'b0; i++)
			@(negedge clk);
		check("grant", 32'(external_bus_grant_n), 0);
		external_bus_request_n = 1'b1;
		@(negedge clk);
		check("grant", 32'(external_bus_grant_n), 1);
		end_sim();
	end
endmodule : tb
